// ===== bench/gpa_pins.sv
// pin model for port a: resolves each pad from the block's enable and the outside level
// assumes the bench supplies the level that outside parts put on undriven pins
`timescale 1ns/1ps
`default_nettype none
module gpa_pins (
   // block side
   input wire gpa_pkg::gpa_byte_t padOut,
   input wire gpa_pkg::gpa_byte_t padOe,
   // outside level on released pins
   input wire gpa_pkg::gpa_byte_t extLevel,
   // level seen back by the block
   output var gpa_pkg::gpa_byte_t padIn
);
   // driven pins show the block's value, released pins the outside level
   always_comb begin
      padIn = (padOut & padOe) | (extLevel & ~padOe);
   end
endmodule : gpa_pins
`default_nettype wire

// ===== bench/gpa_port_bench.sv
// self-checking bench for the port a block: register tasks, pin and steering checks
// assumes the pin model resolves padIn and the bench drives all peripheral lines
`timescale 1ns/1ps
`default_nettype none
`include "gpa_regs.svh"
module gpa_port_bench;
   // clock, reset, enable
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   // register port
   gpa_pkg::gpa_addr_t regAddr = 3'h0;
   gpa_pkg::gpa_byte_t regWrData = 8'h00;
   logic regWr = 1'h0;
   logic regRd = 1'h0;
   gpa_pkg::gpa_byte_t regRdData;
   // pads and outside level
   gpa_pkg::gpa_byte_t padIn, padOut, padOe;
   gpa_pkg::gpa_byte_t extLevel = 8'h00;
   logic [5:0] inBufDisable;
   // peripheral lines
   logic srNqOut = 1'h0, srNqEn = 1'h0, cmp2Out = 1'h0, cmp2En = 1'h0, cc3Out = 1'h0, cc3En = 1'h0;
   logic cc2Out = 1'h0, cc2En = 1'h0, pwm2bOut = 1'h0, pwm2bEn = 1'h0, pbBit5In = 1'h1, pcBit4In = 1'h0;
   logic timer1Gate, slaveSelIn, pc6Drive, pc6Val, pb5Drive, pb5Val;
   logic pc0Drive, pc0Val, pc1Drive, pc1Val, pb3Drive, pb3Val;
   // tallies
   int errorCnt = 0;
   int nChecks = 0;

   gpa_port i_gpa_port (.clk(clk), .sys_rst(rst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .inBufDisable(inBufDisable), .srNqOut(srNqOut), .srNqEn(srNqEn), .cmp2Out(cmp2Out), .cmp2En(cmp2En),
      .cc3Out(cc3Out), .cc3En(cc3En), .cc2Out(cc2Out), .cc2En(cc2En), .pwm2bOut(pwm2bOut), .pwm2bEn(pwm2bEn),
      .pbBit5In(pbBit5In), .pcBit4In(pcBit4In), .timer1Gate(timer1Gate), .slaveSelIn(slaveSelIn),
      .pc6Drive(pc6Drive), .pc6Val(pc6Val), .pb5Drive(pb5Drive), .pb5Val(pb5Val), .pc0Drive(pc0Drive),
      .pc0Val(pc0Val), .pc1Drive(pc1Drive), .pc1Val(pc1Val), .pb3Drive(pb3Drive), .pb3Val(pb3Val));

   gpa_pins i_gpa_pins (.padOut(padOut), .padOe(padOe), .extLevel(extLevel), .padIn(padIn));

   // free-running clock
   initial begin
      forever #20 clk = ~clk;
   end

   // one compare, counted; mismatch reported
   task automatic check(input string what, input gpa_pkg::gpa_byte_t seen, input gpa_pkg::gpa_byte_t exp);
      nChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one-cycle write strobe
   task automatic regWrite(input gpa_pkg::gpa_addr_t a, input gpa_pkg::gpa_byte_t d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
   endtask : regWrite

   // one-cycle read strobe, data checked in the following cycle
   task automatic regRead(input gpa_pkg::gpa_addr_t a, input gpa_pkg::gpa_byte_t exp, input string what);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      #1;
      check(what, regRdData, exp);
   endtask : regRead

   // lets registered pins and the pin loop settle
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   // verdict and end of run
   task automatic completeRun;
      if (errorCnt == 0 && nChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : completeRun

   // hang guard
   initial begin
      #100000;
      errorCnt++;
      completeRun();
   end

   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      settle();
      check("padOe", padOe, 8'h00);
      check("bufOff", {2'h0, inBufDisable}, 8'h3f);
      regRead(`GPA_OFS_DIR, 8'hff, "dir");
      regRead(`GPA_OFS_ANSEL, 8'h3f, "ansel");
      regRead(`GPA_OFS_STEER, 8'h00, "steer");
      @(posedge clk);
      extLevel <= 8'hff;
      settle();
      regRead(`GPA_OFS_PINS, 8'hc0, "pins");
      regWrite(`GPA_OFS_LATCH, 8'ha5);
      regRead(`GPA_OFS_LATCH, 8'ha5, "latch");
      regWrite(`GPA_OFS_PINS, 8'h3c);
      regWrite(`GPA_OFS_DIR, 8'h00);
      regRead(`GPA_OFS_LATCH, 8'h3c, "latch");
      settle();
      check("padOe", padOe, 8'hff);
      check("padOut", padOut, 8'h3c);
      regRead(`GPA_OFS_PINS, 8'h00, "pins");
      regWrite(`GPA_OFS_ANSEL, 8'hc0);
      regRead(`GPA_OFS_ANSEL, 8'h00, "ansel");
      regWrite(`GPA_OFS_DIR, 8'hf0);
      @(posedge clk);
      extLevel <= 8'ha0;
      settle();
      check("bufOff", {2'h0, inBufDisable}, 8'h00);
      check("padOe", padOe, 8'h0f);
      regRead(`GPA_OFS_PINS, 8'hac, "pins");
      regWrite(`GPA_OFS_BITMOD, 8'h09);
      regRead(`GPA_OFS_LATCH, 8'hae, "latch");
      regRead(`GPA_OFS_BITMOD, 8'h00, "bitmod");
      regRead(3'h7, 8'h00, "unmapped");
      @(posedge clk);
      cc3En <= 1'h1;
      cc3Out <= 1'h1;
      pwm2bEn <= 1'h1;
      cc2En <= 1'h1;
      cc2Out <= 1'h1;
      // order: pc6 pb5 pc0 pc1 pb3 drives, gate, select
      for (int i = 0; i < 2; i++) begin
         regWrite(`GPA_OFS_STEER, (i == 1) ? 8'hff : 8'h00);
         settle();
         check("steer", {1'h0, pc6Drive, pb5Drive, pc0Drive, pc1Drive, pb3Drive, timer1Gate, slaveSelIn},
            (i == 1) ? 8'h24 : 8'h5b);
      end
      check("pb5Val", {7'h0, pb5Val}, 8'h01);
      regRead(`GPA_OFS_DIR, 8'hf0, "dir");
      regRead(`GPA_OFS_STEER, 8'h7f, "steer");
      @(posedge clk);
      srNqEn <= 1'h1;
      cmp2En <= 1'h1;
      cmp2Out <= 1'h1;
      settle();
      check("padOut", padOut, 8'hae);
      @(posedge clk);
      srNqEn <= 1'h0;
      settle();
      check("padOut", padOut, 8'haf);
      @(posedge clk);
      cmp2Out <= 1'h0;
      regWrite(`GPA_OFS_STEER, 8'h00);
      settle();
      check("padOut", padOut, 8'h8e);
      @(posedge clk);
      ce <= 1'h0;
      regWrite(`GPA_OFS_LATCH, 8'h11);
      @(posedge clk);
      ce <= 1'h1;
      regRead(`GPA_OFS_LATCH, 8'hae, "frozen");
      @(posedge clk);
      rst <= 1'h1;
      @(posedge clk);
      rst <= 1'h0;
      regRead(`GPA_OFS_DIR, 8'hff, "dir");
      completeRun();
   end
endmodule : gpa_port_bench
`default_nettype wire

// ===== core/gpa_pkg.sv
// shared types of the port a block
// assumes nothing beyond a systemverilog compiler
package gpa_pkg;
   // one register or port byte
   typedef logic [7:0] gpa_byte_t;
   // register index
   typedef logic [2:0] gpa_addr_t;
endpackage : gpa_pkg

// ===== core/gpa_port.sv
// port a logic: direction, latch, analog select, pin steering
// assumes synchronous pad inputs and one 25 mhz clock
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gpa_regs.svh"
module gpa_port (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // register port
   input wire gpa_pkg::gpa_addr_t regAddr,
   input wire gpa_pkg::gpa_byte_t regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output gpa_pkg::gpa_byte_t regRdData,
   // port a pads
   input wire gpa_pkg::gpa_byte_t padIn,
   output gpa_pkg::gpa_byte_t padOut,
   output gpa_pkg::gpa_byte_t padOe,
   output logic [5:0] inBufDisable,
   // peripheral outputs that want a pin
   input wire logic srNqOut,
   input wire logic srNqEn,
   input wire logic cmp2Out,
   input wire logic cmp2En,
   input wire logic cc3Out,
   input wire logic cc3En,
   input wire logic cc2Out,
   input wire logic cc2En,
   input wire logic pwm2bOut,
   input wire logic pwm2bEn,
   // port b and c levels for steered inputs
   input wire logic pbBit5In,
   input wire logic pcBit4In,
   // steered peripheral inputs
   output logic timer1Gate,
   output logic slaveSelIn,
   // overrides for port b and c pins
   output logic pc6Drive,
   output logic pc6Val,
   output logic pb5Drive,
   output logic pb5Val,
   output logic pc0Drive,
   output logic pc0Val,
   output logic pc1Drive,
   output logic pc1Val,
   output logic pb3Drive,
   output logic pb3Val
);

   // replace one bit of a byte
   function automatic gpa_pkg::gpa_byte_t setBit(
      input gpa_pkg::gpa_byte_t base,
      input logic [2:0] idx,
      input logic val);
      gpa_pkg::gpa_byte_t res;
      res = base;
      res[idx] = val;
      return res;
   endfunction : setBit

   // register state
   gpa_pkg::gpa_byte_t dir_ff; // direction, one = input
   gpa_pkg::gpa_byte_t lat_ff; // output latch
   logic [5:0] ansel_ff; // analog select, pins 5..0
   logic [6:0] steer_ff; // pin steering bits 6..0
   // next values of the outputs
   gpa_pkg::gpa_byte_t nxt_rdData;
   gpa_pkg::gpa_byte_t nxt_padOut;
   gpa_pkg::gpa_byte_t digIn; // digital view of the pins
   logic wrPins; // write to pin register
   logic wrLat; // write to latch register
   logic wrBit; // single-bit modify
   logic nxt_pb5Val;

   // analog pins read as zero
   assign digIn = padIn & ~{2'h0, ansel_ff};

   // write decode
   assign wrPins = regWr && regAddr == `GPA_OFS_PINS;
   assign wrLat = regWr && regAddr == `GPA_OFS_LATCH;
   assign wrBit = regWr && regAddr == `GPA_OFS_BITMOD;

   // direction register, all inputs after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dir_ff <= `GPA_RST_DIR;
      end else if (ce && regWr && regAddr == `GPA_OFS_DIR) begin
         dir_ff <= regWrData;
      end
   end

   // output latch: pin, latch and bit-modify writes all land here
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lat_ff <= `GPA_RST_LATCH;
      end else if (ce) begin
         if (wrPins || wrLat) begin
            lat_ff <= regWrData;
         end else if (wrBit) begin
            // pin levels read, one bit merged, result stored
            lat_ff <= setBit(digIn, regWrData[`GPA_BM_IDX_HI:0],
                             regWrData[`GPA_BM_VAL]);
         end
      end
   end

   // analog select, analog after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ansel_ff <= `GPA_RST_ANSEL;
      end else if (ce && regWr && regAddr == `GPA_OFS_ANSEL) begin
         ansel_ff <= regWrData[5:0];
      end
   end

   // steering register, bit 7 not stored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         steer_ff <= `GPA_RST_STEER;
      end else if (ce && regWr && regAddr == `GPA_OFS_STEER) begin
         steer_ff <= regWrData[6:0];
      end
   end

   // read mux
   always_comb begin
      nxt_rdData = 8'h00;
      if (regRd) begin
         case (regAddr)
            `GPA_OFS_PINS: nxt_rdData = digIn;
            `GPA_OFS_LATCH: nxt_rdData = lat_ff;
            `GPA_OFS_DIR: nxt_rdData = dir_ff;
            `GPA_OFS_ANSEL: nxt_rdData = {2'h0, ansel_ff};
            `GPA_OFS_STEER: nxt_rdData = {1'b0, steer_ff};
            default: nxt_rdData = 8'h00; // unmapped
         endcase
      end
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (ce) begin
         regRdData <= nxt_rdData;
      end
   end

   // port a pin values: sr inverted output beats comparator2 beats latch
   always_comb begin
      nxt_padOut = lat_ff;
      // pin 0 takes the functions whose select bit is set
      if (srNqEn && steer_ff[`GPA_SR_LATCH_INVERTED_OUTPUT_SEL]) begin
         nxt_padOut[0] = srNqOut;
      end else if (cmp2En && steer_ff[`GPA_C2_SEL]) begin
         nxt_padOut[0] = cmp2Out;
      end
      // pin 5 takes them while the select bit is clear
      if (srNqEn && !steer_ff[`GPA_SR_LATCH_INVERTED_OUTPUT_SEL]) begin
         nxt_padOut[5] = srNqOut;
      end else if (cmp2En && !steer_ff[`GPA_C2_SEL]) begin
         nxt_padOut[5] = cmp2Out;
      end
   end

   // port b bit 5: capture unit 3 ahead of pwm2 b
   assign nxt_pb5Val = (cc3En && steer_ff[`GPA_CC3_SEL]) ? cc3Out : pwm2bOut;

   // pad drivers; direction alone controls the enable
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         padOut <= `GPA_RST_LATCH;
         padOe <= ~`GPA_RST_DIR;
         inBufDisable <= `GPA_RST_ANSEL;
      end else if (ce) begin
         padOut <= nxt_padOut;
         padOe <= ~dir_ff;
         inBufDisable <= ansel_ff;
      end
   end

   // steered inputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer1Gate <= 1'b0;
         slaveSelIn <= 1'b0;
      end else if (ce) begin
         timer1Gate <= steer_ff[`GPA_T1G_SEL] ? pcBit4In : pbBit5In;
         slaveSelIn <= steer_ff[`GPA_SS_SEL] ? digIn[0] : digIn[5];
      end
   end

   // port b and c overrides; the unselected pin is left alone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pc6Drive <= 1'b0;
         pc6Val <= 1'b0;
         pb5Drive <= 1'b0;
         pb5Val <= 1'b0;
         pc0Drive <= 1'b0;
         pc0Val <= 1'b0;
         pc1Drive <= 1'b0;
         pc1Val <= 1'b0;
         pb3Drive <= 1'b0;
         pb3Val <= 1'b0;
      end else if (ce) begin
         pc6Drive <= cc3En && !steer_ff[`GPA_CC3_SEL];
         pc6Val <= cc3Out;
         pb5Drive <= (cc3En && steer_ff[`GPA_CC3_SEL])
                     || (pwm2bEn && steer_ff[`GPA_P2B_SEL]);
         pb5Val <= nxt_pb5Val;
         pc0Drive <= pwm2bEn && !steer_ff[`GPA_P2B_SEL];
         pc0Val <= pwm2bOut;
         pc1Drive <= cc2En && !steer_ff[`GPA_CC2_SEL];
         pc1Val <= cc2Out;
         pb3Drive <= cc2En && steer_ff[`GPA_CC2_SEL];
         pb3Val <= cc2Out;
      end
   end

   // checks, all in the one clock domain
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // a latch write lands whole
   sequence latWriteSeq;
      ce && wrLat;
   endsequence
   // a read strobe on the pin register
   sequence pinReadSeq;
      ce && regRd && regAddr == `GPA_OFS_PINS;
   endsequence

   chk_latch_write_lands: assert property (latWriteSeq |=> lat_ff == $past(regWrData))
      else $error("latch write lost");
   chk_pin_write_lands: assert property (ce && wrPins |=> lat_ff == $past(regWrData))
      else $error("pin register write did not reach latch");
   chk_pin_read_masked: assert property (pinReadSeq |=>
      regRdData == ($past(padIn) & ~{2'h0, $past(ansel_ff)}))
      else $error("pin read not masked by analog select");
   chk_latch_read_back: assert property (ce && regRd && regAddr == `GPA_OFS_LATCH |=>
      regRdData == $past(lat_ff))
      else $error("latch read wrong");
   chk_driver_enable: assert property (ce |=> padOe == ~$past(dir_ff))
      else $error("driver enable not from direction");
   chk_inbuf_off: assert property (ce |=> inBufDisable == $past(ansel_ff))
      else $error("input buffer not disabled by analog bit");
   chk_rmw_merge: assert property (ce && wrBit |=>
      lat_ff[$past(regWrData[2:0])] == $past(regWrData[3])
      && (lat_ff | (8'h01 << $past(regWrData[2:0])))
      == ($past(digIn) | (8'h01 << $past(regWrData[2:0]))))
      else $error("bit modify did not merge pin levels");
   chk_steer_keeps_dir: assert property (ce && regWr && regAddr == `GPA_OFS_STEER |=>
      $stable(dir_ff))
      else $error("steering write changed direction");
   chk_steer_top_zero: assert property (ce && regRd && regAddr == `GPA_OFS_STEER |=>
      regRdData[7] == 1'b0)
      else $error("steering bit 7 not zero");
   chk_cc3_route: assert property (ce |=>
      pc6Drive == $past(cc3En && !steer_ff[6]))
      else $error("capture unit 3 misrouted");
   chk_gate_route: assert property (ce |=>
      timer1Gate == ($past(steer_ff[5]) ? $past(pcBit4In) : $past(pbBit5In)))
      else $error("timer1 gate from wrong pin");
   chk_sr_latch_inverted_output_priority: assert property (ce && srNqEn && steer_ff[3] |=>
      padOut[0] == $past(srNqOut))
      else $error("sr inverted output lost pin 0");
   chk_reset_values: assert property (disable iff (1'b0) sys_rst |=>
      steer_ff == 7'h00 && ansel_ff == 6'h3f && dir_ff == 8'hff)
      else $error("reset values wrong");

   // a low enable freezes the latch
   chk_freeze_latch: assert property (!ce |=> $stable(lat_ff))
      else $error("latch moved while frozen");

   // a low enable freezes the direction bits
   chk_freeze_dir: assert property (!ce |=> $stable(dir_ff))
      else $error("direction moved while frozen");

   // read data falls back to zero without a strobe
   chk_rd_idle_zero: assert property (ce && !regRd |=> regRdData == 8'h00)
      else $error("read data not zero when idle");

   // a direction write lands whole
   chk_dir_write: assert property (ce && regWr && regAddr == `GPA_OFS_DIR |=>
      dir_ff == $past(regWrData))
      else $error("direction write lost");

   // an analog select write lands in bits 5..0
   chk_ansel_write: assert property (ce && regWr && regAddr == `GPA_OFS_ANSEL |=>
      ansel_ff == $past(regWrData[5:0]))
      else $error("analog select write lost");

   // a steering write lands in bits 6..0
   chk_steer_write: assert property (ce && regWr && regAddr == `GPA_OFS_STEER |=>
      steer_ff == $past(regWrData[6:0]))
      else $error("steering write lost");

   // unimplemented analog bits read as zero
   chk_ansel_read_top: assert property (ce && regRd && regAddr == `GPA_OFS_ANSEL |=>
      regRdData[7:6] == 2'h0)
      else $error("analog select top bits not zero");

   // slave select follows its steering bit
   chk_ss_route: assert property (ce |=>
      slaveSelIn == ($past(steer_ff[1]) ? $past(digIn[0]) : $past(digIn[5])))
      else $error("slave select from wrong pin");

   // capture unit 2, when enabled, drives exactly one of its pins
   chk_cc2_route: assert property (ce |=>
      pc1Drive == $past(cc2En && !steer_ff[0]) && pb3Drive == $past(cc2En && steer_ff[0]))
      else $error("capture unit 2 misrouted");

   // capture unit 2 value reaches both candidate pins
   chk_cc2_value: assert property (ce |=> pb3Val == $past(cc2Out) && pc1Val == $past(cc2Out))
      else $error("capture unit 2 value wrong");

   // pwm2 b stays on port c bit 0 while its bit is clear
   chk_pwm2b_route: assert property (ce |=> pc0Drive == $past(pwm2bEn && !steer_ff[4]))
      else $error("pwm2 b misrouted");

   // pwm2 b value on port c bit 0
   chk_pc0_value: assert property (ce |=> pc0Val == $past(pwm2bOut))
      else $error("pwm2 b value wrong");

   // capture unit 3 value on port c bit 6
   chk_pc6_value: assert property (ce |=> pc6Val == $past(cc3Out))
      else $error("capture unit 3 value wrong");

   // capture unit 3 owns port b bit 5 when steered there
   chk_pb5_priority: assert property (ce && cc3En && steer_ff[6] |=> pb5Val == $past(cc3Out))
      else $error("capture unit 3 lost port b bit 5");

   // otherwise pwm2 b supplies port b bit 5
   chk_pb5_fallback: assert property (ce && !(cc3En && steer_ff[6]) |=>
      pb5Val == $past(pwm2bOut))
      else $error("port b bit 5 value wrong");

   // with no peripheral on port a the pins show the latch
   chk_pad_latch_plain: assert property (ce && !srNqEn && !cmp2En |=> padOut == $past(lat_ff))
      else $error("pins not showing latch");

   // pins without steered functions always show the latch
   chk_pad_fixed_pins: assert property (ce |=>
      padOut[4:1] == $past(lat_ff[4:1]) && padOut[7:6] == $past(lat_ff[7:6]))
      else $error("fixed pins not showing latch");

   // sr inverted output owns pin 5 while its bit is clear
   chk_sr_latch_inverted_output_pin5: assert property (ce && srNqEn && !steer_ff[3] |=> padOut[5] == $past(srNqOut))
      else $error("sr inverted output lost pin 5");

   // comparator2 reaches pin 0 when the latch output is idle
   chk_cmp2_pin0: assert property (ce && !srNqEn && cmp2En && steer_ff[2] |=>
      padOut[0] == $past(cmp2Out))
      else $error("comparator2 lost pin 0");

   // comparator2 reaches pin 5 when the latch output is idle
   chk_cmp2_pin5: assert property (ce && !srNqEn && cmp2En && !steer_ff[2] |=>
      padOut[5] == $past(cmp2Out))
      else $error("comparator2 lost pin 5");

   // note: the checks above sample registered outputs one edge after their cause,
   // so every antecedent except those of the reset and freeze checks carries ce; a frozen cycle leaves the outputs unchanged

endmodule : gpa_port
`default_nettype wire

// ===== core/gpa_regs.svh
// register offsets, reset values and field positions of the port a block
// assumes a 3-bit register index and 8-bit register data
//
// How it works
// - latch register write equals pin register write
// - latch reads latch, pin register reads pins
// - analog bit disables digital input buffer
// - enabled peripheral replaces latch on pin
// - direction one tristates, zero drives latch
// - port a is eight independent pins
// - bit-modify writes merge into latch (read-modify-write)
// - direction controls driver even in analog
// - analog pins read back as zero
// - analog bits change digital outputs only through masked pin reads (bit-modify, slave select)
// - analog bits reset to analog mode
// - steering never changes direction bits
// - overrides follow function to selected pin
// - bit 6 moves capture unit 3 pin
// - bit 5 picks timer1 gate pin
// - bit 4 moves pwm2 b output pin
// - bit 3 moves sr inverted output pin
// - bit 2 moves comparator2 output pin
// - bit 1 picks slave select pin
// - bit 0 moves capture unit 2 pin
// - steering bit 7 reads zero, resets zero
// - highest priority function owns the pin
`ifndef GPA_REGS_SVH
`define GPA_REGS_SVH
// register indices
`define GPA_OFS_PINS 3'h0
`define GPA_OFS_LATCH 3'h1
`define GPA_OFS_DIR 3'h2
`define GPA_OFS_ANSEL 3'h3
`define GPA_OFS_STEER 3'h4
`define GPA_OFS_BITMOD 3'h5
// reset values
`define GPA_RST_DIR 8'hff
`define GPA_RST_LATCH 8'h00
`define GPA_RST_ANSEL 6'h3f
`define GPA_RST_STEER 7'h00
// steering field positions
`define GPA_CC3_SEL 6
`define GPA_T1G_SEL 5
`define GPA_P2B_SEL 4
`define GPA_SR_LATCH_INVERTED_OUTPUT_SEL 3
`define GPA_C2_SEL 2
`define GPA_SS_SEL 1
`define GPA_CC2_SEL 0
// bit-modify register fields
`define GPA_BM_IDX_HI 2
`define GPA_BM_VAL 3
`endif
